// File: verilog/cocs_defs.svh
// Purpose: Constants for the constant off-time chopper and current scaling
// Assumes: 32-bit AXI4-Lite register words, 125 MHz aclk
// Notes:   All offsets are byte addresses
`ifndef COCS_DEFS_SVH
`define COCS_DEFS_SVH
`define COCS_ADDR_CTRL       8'h00
`define COCS_ADDR_CURRENT    8'h04
`define COCS_ADDR_SCALER     8'h08
`define COCS_ADDR_SINE       8'h0C
`define COCS_ADDR_STATUS     8'h10
`define COCS_ADDR_TARGET     8'h14
// Control word field positions
`define COCS_F_HYST_START_LSB 4
`define COCS_F_HYST_END_LSB  7
`define COCS_F_FDMSB         11
`define COCS_F_MODE_SEL      14
`define COCS_F_FD_COMP_DIS   12
`define COCS_F_LOADSPD       18
`define COCS_F_FULLSTEP      19
// Current word fields
`define COCS_F_HOLD_LSB      0
`define COCS_F_RUN_LSB       8
`define COCS_F_ADAPT_LSB     16
`define COCS_F_SRC_LSB       24
`define COCS_F_STANDSTILL    26
// Reset values
`define COCS_RST_CTRL        32'h0000_0000
`define COCS_RST_CURRENT     32'h0000_1F10
`define COCS_RST_SCALER      8'h00
`define COCS_RST_SINE        8'h00
// Sine offset zero code, table amplitude, full-scale sense code
`define COCS_OFFS_ZERO       3
`define COCS_SINE_AMPL       248
`define COCS_VFS_CODE        16'hFFFF
// Fast decay unit time in ns, and cycles per unit
`define COCS_FD_UNIT_NS      256
`define COCS_CLK_NS          8
`define COCS_FD_UNIT_CYC     ((`COCS_FD_UNIT_NS + `COCS_CLK_NS - 1) / `COCS_CLK_NS)
// Comparator lag after the bridge switches: model stage plus sync
`define COCS_COMP_BLANK_CYC  3
`endif

// File: verilog/cocs_pkg.sv
// Purpose: Types for the constant off-time chopper block
// Assumes: Used with cocs_defs.svh
// Notes:   States use Gray codes along on -> fast -> slow
package cocs_pkg;
  typedef enum logic [1:0]
  {
    COCS_ON   = 2'b00,
    COCS_FAST = 2'b01,
    COCS_SLOW = 2'b11
  } cocs_phase_t;
  typedef enum logic [1:0]
  {
    COCS_SRC_RUN   = 2'b00,
    COCS_SRC_HOLD  = 2'b01,
    COCS_SRC_ADAPT = 2'b10
  } cocs_src_t;
endpackage : cocs_pkg

// File: verilog/cocs_target_calc.sv
// Purpose: Registered coil current target from scaler, sine value and scale
// Assumes: Inputs quasi-static against the one-cycle pipeline
// Notes:   Result is a 16-bit sense threshold code
`include "cocs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module cocs_target_calc
  import cocs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  global_current_scaler,
  input  wire logic [7:0]  sine_table_value,
  input  wire logic [4:0]  current_scale,
  output logic      [15:0] target
);
  logic [8:0]  gs_eff;
  logic [5:0]  cs_eff;
  logic [31:0] prod;
  logic [31:0] quot;
  // Zero scaler means full scale 256
  assign gs_eff = (global_current_scaler == 8'h00) ? 9'h100 : {1'b0, global_current_scaler};
  assign cs_eff = {1'b0, current_scale} + 6'h01;
  // Vfs * gs/256 * sine/248 * (cs+1)/32, Vfs taken as 255 so full scale reads 0x00FF
  assign prod = 32'(gs_eff) * 32'(sine_table_value) * 32'(cs_eff);
  assign quot = (prod * 32'(`COCS_VFS_CODE >> 8)) /
                (32'd`COCS_SINE_AMPL * 32'd32 * 32'd256);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      target <= 16'h0000;
    else
      target <= (quot > 32'h0000_FFFF) ? 16'hFFFF : quot[15:0];
  end

  property p_full_scale_zero;
    @(posedge aclk) disable iff (!aresetn)
    (global_current_scaler == 8'h00 && sine_table_value == 8'd248 && current_scale == 5'd31)
      |=> (target == 16'h00FF);
  endproperty
  a_full_scale_zero: assert property (p_full_scale_zero)
    else $error("Scaler zero not full scale");
  property p_zero_sine;
    @(posedge aclk) disable iff (!aresetn)
    (sine_table_value == 8'h00) |=> (target == 16'h0000);
  endproperty
  a_zero_sine: assert property (p_zero_sine)
    else $error("Zero sine gave nonzero target");
endmodule : cocs_target_calc
`default_nettype wire

// File: verilog/cocs_chopper.sv
// Purpose: Constant off-time chopper with sine offset and current scaling
// Assumes: Comparator input is asynchronous; AXI4-Lite master is well behaved
// Notes:   Slow decay uses a fixed window of four fast decay units
//
// Contract
// - Classic chopper when mode bit set, or load-speed mode in fullstep.
// - On phase ends at comparator trip, then a fixed fast decay follows.
// - Fast decay field is msb plus start bits; zero means slow only.
// - End field is sine offset: 0-2 negative, 3 zero, 4-15 positive.
// - Comparator ends fast decay early unless the disable bit is set.
// - Eight-bit global scaler multiplies the target in 1/256 steps.
// - Five-bit scale from run, hold or adaptive; readable by software.
// - Global scaler zero counts as full scale 256.
// - Target is Vfs times scaler, sine over 248, scale plus one over 32.
`include "cocs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module cocs_chopper
  import cocs_pkg::*;
#(
  parameter int FD_UNIT_CYC = `COCS_FD_UNIT_CYC,
  parameter int SLOW_CYC    = `COCS_FD_UNIT_CYC * 4
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sense_comp,
  output logic             bridge_on,
  output logic             bridge_fast,
  output logic [15:0]      coil_target,
  output logic             classic_active
);
  logic [31:0]   chop_ctrl;
  logic [31:0]   curconf;
  logic [7:0]    gscaler;
  logic [7:0]    sine_raw;
  logic          aw_hold;
  logic          w_hold;
  logic [7:0]    aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic [1:0]    comp_sync;
  cocs_phase_t   phase;
  cocs_phase_t   next_phase;
  logic [11:0]   fd_cnt;
  logic [11:0]   sd_cnt;
  logic [15:0]   raw_target;
  logic [31:0]   rd_mux;
  logic          rd_hit;
  logic          wr_hit;

  // Register write path: address and data taken in either order
  wire       do_write = aw_hold && w_hold && !s_axi_bvalid;
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_hit = (aw_addr == `COCS_ADDR_CTRL) || (aw_addr == `COCS_ADDR_CURRENT) ||
                  (aw_addr == `COCS_ADDR_SCALER) || (aw_addr == `COCS_ADDR_SINE);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : merge

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_hold <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_hold <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chop_ctrl <= `COCS_RST_CTRL;
      curconf  <= `COCS_RST_CURRENT;
      gscaler  <= `COCS_RST_SCALER;
      sine_raw <= `COCS_RST_SINE;
    end
    else if (do_write)
    begin
      if (aw_addr == `COCS_ADDR_CTRL)
        chop_ctrl <= merge(chop_ctrl, w_data, w_strb);
      if (aw_addr == `COCS_ADDR_CURRENT)
        curconf <= merge(curconf, w_data, w_strb);
      if (aw_addr == `COCS_ADDR_SCALER && w_strb[0])
        gscaler <= w_data[7:0];
      if (aw_addr == `COCS_ADDR_SINE && w_strb[0])
        sine_raw <= w_data[7:0];
    end
  end

  // Field decode
  wire [2:0] hyst_start_field = chop_ctrl[`COCS_F_HYST_START_LSB +: 3];
  wire [3:0] hyst_end_field = chop_ctrl[`COCS_F_HYST_END_LSB +: 4];
  wire       fast_decay_msb = chop_ctrl[`COCS_F_FDMSB];
  wire       chopper_mode_select = chop_ctrl[`COCS_F_MODE_SEL];
  wire       fd_comp_dis = chop_ctrl[`COCS_F_FD_COMP_DIS];
  wire [3:0] fast_decay_time = {fast_decay_msb, hyst_start_field};
  wire [4:0] hold_current = curconf[`COCS_F_HOLD_LSB +: 5];
  wire [4:0] run_current  = curconf[`COCS_F_RUN_LSB +: 5];
  wire [4:0] adapt_cur    = curconf[`COCS_F_ADAPT_LSB +: 5];
  wire [1:0] cur_src      = curconf[`COCS_F_SRC_LSB +: 2];
  wire       standstill   = curconf[`COCS_F_STANDSTILL];
  // Adaptive source overrides; otherwise standstill picks hold
  wire [4:0] current_scale = (cur_src == COCS_SRC_ADAPT) ? adapt_cur :
                             standstill ? hold_current : run_current;
  assign classic_active = chopper_mode_select ||
                          (chop_ctrl[`COCS_F_LOADSPD] && chop_ctrl[`COCS_F_FULLSTEP]);

  // Offset: code minus 3, clamped at zero current
  wire signed [9:0] sine_ofs = $signed({6'b000000, hyst_end_field}) -
                               $signed(10'(`COCS_OFFS_ZERO));
  wire signed [9:0] sine_sum = $signed({2'b00, sine_raw}) + (classic_active ? sine_ofs : 10'sd0);
  wire [7:0] sine_table_value = sine_sum[9] ? 8'h00 :
                                (sine_sum > 10'sd255) ? 8'hFF : sine_sum[7:0];

  cocs_target_calc u_calc
  (
    .aclk                  (aclk),
    .aresetn               (aresetn),
    .global_current_scaler (gscaler),
    .sine_table_value      (sine_table_value),
    .current_scale         (current_scale),
    .target                (raw_target)
  );
  assign coil_target = raw_target;

  // Readback
  assign rd_hit = (s_axi_araddr == `COCS_ADDR_CTRL) || (s_axi_araddr == `COCS_ADDR_CURRENT) ||
                  (s_axi_araddr == `COCS_ADDR_SCALER) || (s_axi_araddr == `COCS_ADDR_SINE) ||
                  (s_axi_araddr == `COCS_ADDR_STATUS) || (s_axi_araddr == `COCS_ADDR_TARGET);
  always_comb
  begin
    unique case (s_axi_araddr)
      `COCS_ADDR_CTRL:     rd_mux = chop_ctrl;
      `COCS_ADDR_CURRENT:  rd_mux = curconf;
      `COCS_ADDR_SCALER:   rd_mux = {24'h00_0000, gscaler};
      `COCS_ADDR_SINE:     rd_mux = {24'h00_0000, sine_raw};
      `COCS_ADDR_STATUS:   rd_mux = {24'h00_0000, classic_active, phase, current_scale};
      `COCS_ADDR_TARGET:   rd_mux = {16'h0000, raw_target};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Comparator is a pin: two stages before use
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      comp_sync <= 2'b00;
    else
      comp_sync <= {comp_sync[0], sense_comp};
  end
  wire comp = comp_sync[1];

  // Comparator high means target reached on the active half cycle
  wire [11:0] fd_len = 12'(fast_decay_time) * 12'(FD_UNIT_CYC);
  wire fd_done = (fd_cnt >= fd_len - 12'd1);
  // The on-phase trip is still seen for a few cycles; ignore it then
  wire fd_blank = (fd_cnt < 12'(`COCS_COMP_BLANK_CYC));
  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      COCS_ON:
        if (comp)
          next_phase = (fast_decay_time == 4'h0) ? COCS_SLOW : COCS_FAST;
      COCS_FAST:
        if (fd_done || (!fd_comp_dis && comp && !fd_blank))
          next_phase = COCS_SLOW;
      COCS_SLOW:
        if (sd_cnt >= 12'(SLOW_CYC - 1))
          next_phase = COCS_ON;
      default:
        next_phase = COCS_SLOW;
    endcase
    if (!classic_active)
      next_phase = COCS_SLOW;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      phase <= COCS_SLOW;
    else
      phase <= next_phase;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fd_cnt <= 12'h000;
      sd_cnt <= 12'h000;
    end
    else
    begin
      fd_cnt <= (phase == COCS_FAST && next_phase == COCS_FAST) ? fd_cnt + 12'd1 : 12'h000;
      sd_cnt <= (phase == COCS_SLOW && next_phase == COCS_SLOW) ? sd_cnt + 12'd1 : 12'h000;
    end
  end

  assign bridge_on   = (phase == COCS_ON);
  assign bridge_fast = (phase == COCS_FAST);

  property p_fast_bounded;
    @(posedge aclk) disable iff (!aresetn)
    (phase == COCS_FAST) |-> (fd_cnt < fd_len);
  endproperty
  a_fast_bounded: assert property (p_fast_bounded)
    else $error("Fast decay overran its length");
  property p_on_trip;
    @(posedge aclk) disable iff (!aresetn)
    (phase == COCS_ON && comp && classic_active && fast_decay_time != 4'h0) |=> (phase == COCS_FAST);
  endproperty
  a_on_trip: assert property (p_on_trip)
    else $error("Trip did not start fast decay");
  property p_slow_only;
    @(posedge aclk) disable iff (!aresetn)
    (fast_decay_time == 4'h0 && phase == COCS_ON && comp) |=> (phase != COCS_FAST);
  endproperty
  a_slow_only: assert property (p_slow_only)
    else $error("Fast decay with zero setting");
  property p_comp_end;
    @(posedge aclk) disable iff (!aresetn)
    (phase == COCS_FAST && comp && !fd_comp_dis && !fd_blank) |=> (phase == COCS_SLOW);
  endproperty
  a_comp_end: assert property (p_comp_end)
    else $error("Comparator did not end fast decay");
  property p_time_only;
    @(posedge aclk) disable iff (!aresetn)
    (phase == COCS_FAST && fd_comp_dis && !fd_done && classic_active) |=> (phase == COCS_FAST);
  endproperty
  a_time_only: assert property (p_time_only)
    else $error("Fast decay ended early with comparator off");
  property p_mode;
    @(posedge aclk) disable iff (!aresetn)
    (!classic_active) |=> (phase == COCS_SLOW);
  endproperty
  a_mode: assert property (p_mode)
    else $error("Chopper ran outside classic mode");
  property p_offset_zero;
    @(posedge aclk) disable iff (!aresetn)
    (classic_active && hyst_end_field == 4'd3) |-> (sine_table_value == sine_raw);
  endproperty
  a_offset_zero: assert property (p_offset_zero)
    else $error("Offset code 3 not neutral");
  property p_scale_src;
    @(posedge aclk) disable iff (!aresetn)
    (cur_src != COCS_SRC_ADAPT && !standstill) |-> (current_scale == run_current);
  endproperty
  a_scale_src: assert property (p_scale_src)
    else $error("Run current not selected");
endmodule : cocs_chopper
`default_nettype wire

// File: tb/cocs_coil_model.sv
// Purpose: Coil and sense comparator stand-in for the chopper bench
// Assumes: Comparator level is high while coil current is at target
// Notes:   Trip time is set by the bench, not by current math
`timescale 1ns/1ps
`default_nettype none
module cocs_coil_model
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       bridge_on,
  input  wire logic       bridge_fast,
  input  wire logic [7:0] on_len,
  input  wire logic       trip_fast,
  output logic            sense_comp
);
  logic [7:0] rise_cnt;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rise_cnt   <= 8'h00;
      sense_comp <= 1'b0;
    end
    else
    begin
      rise_cnt   <= bridge_on ? rise_cnt + 8'h01 : 8'h00;
      // Reverse current passes target early in fast decay only when asked
      sense_comp <= bridge_on ? (rise_cnt >= on_len) : (bridge_fast & trip_fast);
    end
  end
endmodule : cocs_coil_model
`default_nettype wire

// File: tb/cocs_chopper_tb.sv
// Purpose: Self-checking bench for the off-time chopper block
// Assumes: Short fast decay unit and slow window keep the run brief
// Notes:   Target law checked by ratios, and by absolute reads of full scale 0x00FF and zero sine
`timescale 1ns/1ps
`default_nettype none
module cocs_chopper_tb;
  import cocs_pkg::*;
  localparam int FDU = 2;
  logic        aclk, aresetn, trip_fast;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, on_len;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        sense_comp, bridge_on, bridge_fast, classic_active;
  logic [15:0] coil_target;
  int          err_total, num_checks;
  logic [1:0]  last_bresp;

  cocs_chopper #(.FD_UNIT_CYC(FDU), .SLOW_CYC(8)) uut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sense_comp, .bridge_on,
    .bridge_fast, .coil_target, .classic_active);
  cocs_coil_model model (.aclk, .aresetn, .bridge_on, .bridge_fast, .on_len, .trip_fast,
    .sense_comp);

  always #4 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (err_total == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw;
    ta = 0;
    tw = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ta && tw))
    begin
      @(negedge aclk);
      ta = ta | (s_axi_awvalid & s_axi_awready);
      tw = tw | (s_axi_wvalid & s_axi_wready);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do
    begin
      @(negedge aclk);
      ta = s_axi_bvalid;
      last_bresp = s_axi_bresp;
      @(posedge aclk);
    end while (!ta);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit t;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(negedge aclk);
      t = s_axi_arvalid & s_axi_arready;
      @(posedge aclk);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do
    begin
      @(negedge aclk);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end while (!t);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Target read back over the bus must match the port
  task automatic tgt(input logic [7:0] gs, input logic [7:0] sn, output logic [15:0] t);
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'h08, {24'h00_0000, gs});
    wr(8'h0C, {24'h00_0000, sn});
    rd(8'h14, d, r);
    chk(coil_target, d[15:0]);
    t = d[15:0];
  endtask : tgt

  function automatic logic [17:0] dif(input logic [17:0] a, input logic [17:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : dif

  // One on phase and the fast decay after it, counted in whole cycles
  task automatic cyc(output int k, output int f);
    k = 0;
    f = 0;
    @(negedge aclk);
    while (!bridge_on) @(negedge aclk);
    while (bridge_on)
    begin
      k++;
      @(negedge aclk);
    end
    while (bridge_fast)
    begin
      f++;
      @(negedge aclk);
    end
    @(posedge aclk);
  endtask : cyc

  task automatic test_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rd(8'h04, d, r);
    chk(d, 32'h0000_1F10);
    rd(8'h10, d, r);
    chk(d[7:0], 8'h7F);
    chk({bridge_on, bridge_fast, classic_active}, 3'h0);
    rd(8'h18, d, r);
    chk(r, 2'h2);
    chk(d, 32'h0000_0000);
    wr(8'h18, 32'h0000_0001);
    chk(last_bresp, 2'h2);
    // Run, then standstill picks hold, then adaptive source
    for (int s = 0; s < 3; s++)
    begin
      wr(8'h04, 32'h0009_1103 | ((s == 1) ? 32'h0400_0000 : (s << 24)));
      chk(last_bresp, 2'h0);
      rd(8'h10, d, r);
      chk(d[4:0], (s == 0) ? 17 : (s == 1) ? 3 : 9);
    end
    s_axi_wstrb <= 4'h2;
    wr(8'h04, 32'h0000_0000);
    s_axi_wstrb <= 4'hF;
    rd(8'h04, d, r);
    chk(d, 32'h0209_0003);
    wr(8'h04, 32'h0000_1F10);
  endtask : test_regs

  task automatic test_modes();
    logic [31:0] cw [4] = '{32'h0000_4000, 32'h000C_0000, 32'h0004_0000, 32'h0008_0000};
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, cw[i]);
      rd(8'h10, d, r);
      chk({d[7], classic_active}, (i < 2) ? 2'h3 : 2'h0);
    end
  endtask : test_modes

  task automatic test_target();
    logic [15:0] t0, t1;
    wr(8'h00, 32'h0000_0000);
    tgt(8'h00, 8'd248, t0);
    chk(t0, 16'h00FF);
    tgt(8'hFF, 8'd248, t1);
    chk(t0 > t1, 1'b1);
    tgt(8'h00, 8'd124, t0);
    tgt(8'h80, 8'd124, t1);
    chk(dif(t0, 2 * t1) <= 2, 1'b1);
    tgt(8'h00, 8'd62, t1);
    chk(dif(t0, 2 * t1) <= 2, 1'b1);
    tgt(8'h00, 8'd0, t1);
    chk(t1, 16'h0000);
    wr(8'h04, 32'h0000_0F10);
    tgt(8'h00, 8'd124, t1);
    chk(dif(t0, 2 * t1) <= 2, 1'b1);
    wr(8'h04, 32'h0000_1F10);
    tgt(8'h00, 8'd100, t0);
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h00, 32'h0000_4000 | (c << 7));
      tgt(8'h00, 8'd103 - c[7:0], t1);
      chk(t1, t0);
    end
  endtask : test_target

  task automatic test_fast();
    int k, f;
    int fds [4] = '{0, 1, 8, 15};
    foreach (fds[i])
    begin
      wr(8'h00, 32'h0000_5000 | ((fds[i] & 7) << 4) | ((fds[i] >> 3) << 11));
      cyc(k, f);
      repeat (2)
      begin
        cyc(k, f);
        chk(f, fds[i] * FDU);
        chk(k >= 6 && k <= 11, 1'b1);
      end
    end
    trip_fast <= 1'b1;
    wr(8'h00, 32'h0000_4870);
    cyc(k, f);
    cyc(k, f);
    chk(f > 0 && f < 15 * FDU, 1'b1);
    wr(8'h00, 32'h0000_5870);
    cyc(k, f);
    cyc(k, f);
    chk(f, 15 * FDU);
    trip_fast <= 1'b0;
  endtask : test_fast

  task automatic test_off();
    logic seen;
    seen = 1'b0;
    wr(8'h00, 32'h0000_0000);
    repeat (4) @(posedge aclk);
    repeat (40)
    begin
      @(negedge aclk);
      seen = seen | bridge_on | bridge_fast;
    end
    chk(seen, 1'b0);
    @(posedge aclk);
  endtask : test_off

  initial
  begin
    aclk = 0;
    aresetn = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    on_len = 8'd5;
    trip_fast = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_regs();
    test_modes();
    test_target();
    test_fast();
    test_off();
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    tally_and_finish();
  end
endmodule : cocs_chopper_tb
`default_nettype wire
